// File: shared/ccs_defines.svh
// Purpose: Constants of the converter correction store.
// Assumes: 20 MHz user clock, two-wire EEPROM at 100 kHz.
// Notes:   Header only, no logic.
//
// Overview of operation
// [R1] Serial clock and data are only pulled low or released, never driven high.
// [R2] Correction words are signed two's complement 16-bit, -32768 to +32767.
// [R3] Corrections count half converter LSBs, so arithmetic carries one extra fraction bit.
// [R4] Output data has the stored offset subtracted before reaching the output converter.
// [R5] Each input conversion result has the stored offset subtracted.
// [R6] Output data is multiplied by a factor derived from the stored gain word.
// [R7] Input results are multiplied by a factor covering amplifier and converter gain.
// [R8] Every input channel, gain and mode has one offset word and one gain word.
// [R9] A record is four bytes: offset high, offset low, gain high, gain low.
// [R10] Records run converter one to four, channel zero to three, four bytes apart.
// [R11] Differential range blocks sit 128 bytes apart; their upper halves are reserved.
// [R12] Single-ended gain 0.2 reuses the gain 0.16666 correction set.
// [R13] The voltage range stored beside each set can be read to confirm it.
// [R14] Each word is high byte from the lower address, concatenated with the low byte.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CCS_CLK_PERIOD_NS 50
`define CCS_SCL_PERIOD_NS 10000
`define CCS_QTR_CYC (((`CCS_SCL_PERIOD_NS / 4) + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)

// ----------------------------------------
// Byte map
// ----------------------------------------
`define CCS_DIFF_BASE   16'h0000
`define CCS_SE_BASE_DEF 16'h0400
`define CCS_ARNG_DEF    16'h3F00
`define CCS_DAC_DEF     16'h3E00
`define CCS_DRNG_DEF    16'h3F10
`define CCS_DEV_DEF     7'h50
`define CCS_BLK_SHIFT   7
`define CCS_CONV_SHIFT  4
`define CCS_CH_SHIFT    2
`define CCS_REC_BYTES   4
`define CCS_REC_LAST    2'd3
`define CCS_RNG_LAST    2'd0
`define CCS_B_OFS_HI    0
`define CCS_B_OFS_LO    1
`define CCS_B_GN_HI     2
`define CCS_B_GN_LO     3
`define CCS_ACK_BIT     4'd8

// ----------------------------------------
// Arithmetic
// ----------------------------------------
`define CCS_FRAC_SHIFT  1
`define CCS_GAIN_SHIFT  17
`define CCS_SAT_MAX     18'sh07FFF
`define CCS_SAT_MIN     -18'sh08000
`define CCS_OUT_MAX     16'sh7FFF
`define CCS_OUT_MIN     16'sh8000

`endif

// File: shared/ccs_pkg.sv
// Purpose: Types of the converter correction store.
// Assumes: Constants come from ccs_defines.svh.
// Notes:   Types only.
package ccs_pkg;
	typedef enum logic [1:0] {CMD_START = 2'h0, CMD_STOP = 2'h1, CMD_WR = 2'h2, CMD_RD = 2'h3} ccs_cmd_e;
	typedef enum logic {B_IDLE = 1'b0, B_RUN = 1'b1} ccs_bit_e;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0, S_START = 4'h1, S_DEVW = 4'h3, S_AHI = 4'h2, S_ALO = 4'h6,
		S_RSTART = 4'h7, S_DEVR = 4'h5, S_READ = 4'h4, S_STOP = 4'hC
	} ccs_seq_e;
	typedef enum logic [1:0] {J_ADC_REC = 2'h0, J_ADC_RNG = 2'h1, J_DAC_REC = 2'h2, J_DAC_RNG = 2'h3} ccs_job_e;
	typedef enum logic [1:0] {G_0166 = 2'h0, G_0200 = 2'h1, G_0400 = 2'h2, G_0800 = 2'h3} ccs_gain_e;
	typedef struct packed {
		logic signed [15:0] offset;
		logic signed [15:0] gain;
	} ccs_corr_s;
	typedef struct packed {
		logic               valid;
		logic signed [15:0] data;
	} ccs_smp_s;
	typedef struct packed {
		logic [1:0] conv;
		logic [1:0] ch;
		ccs_gain_e  gain;
		logic       se;
		logic [2:0] dac_ch;
	} ccs_sel_s;
endpackage

// File: verilog/ccs_i2c_bit.sv
// Purpose: Two-wire bit engine: start, stop, byte write, byte read.
// Assumes: One command at a time, taken only while ready_o is high.
// Notes:   Each bit is four quarter periods; the slave may stretch the clock.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_i2c_bit #(
	parameter int QTR = `CCS_QTR_CYC
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             cmd_valid_i,
	input  wire ccs_pkg::ccs_cmd_e cmd_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             mack_i,
	output logic                  ready_o,
	output logic                  done_o,
	output logic [7:0]            rdata_o,
	output logic                  nack_o,
	input  wire logic             scl_i,
	output logic                  scl_o,
	output logic                  scl_oe_n_o,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_n_o
);
	import ccs_pkg::*;

	ccs_bit_e    st_q, st_d;
	ccs_cmd_e    cmd_q, cmd_d;
	logic [15:0] div_q, div_d;
	logic [1:0]  ph_q, ph_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d;
	logic        scl_q, scl_d, sda_q, sda_d;
	logic        ack_q, ack_d, nack_q, nack_d, done_q, done_d;
	logic        tick;

	assign tick = (div_q == 16'h0000);

	// ----------------------------------------
	// Quarter-period sequencer
	// ----------------------------------------
	// Next values of the engine; scl_q and sda_q mean "released"
	always_comb begin
		st_d   = st_q;
		cmd_d  = cmd_q;
		ph_d   = ph_q;
		bit_d  = bit_q;
		sh_d   = sh_q;
		scl_d  = scl_q;
		sda_d  = sda_q;
		ack_d  = ack_q;
		nack_d = nack_q;
		done_d = 1'b0;
		div_d  = tick ? 16'(QTR - 1) : div_q - 16'h0001;
		case (st_q)
			B_IDLE: begin
				div_d = 16'(QTR - 1);
				if (cmd_valid_i) begin
					cmd_d = cmd_i;
					sh_d  = wdata_i;
					ack_d = mack_i;
					ph_d  = 2'd0;
					bit_d = 4'd0;
					st_d  = B_RUN;
				end
			end
			B_RUN: begin
				if (tick) begin
					ph_d = ph_q + 2'd1;
					case (cmd_q)
						// Data released first so a repeated start cannot look like a stop
						CMD_START: begin
							case (ph_q)
								2'd0: sda_d = 1'b1;
								2'd1: scl_d = 1'b1;
								2'd2: sda_d = 1'b0;
								default: begin
									scl_d  = 1'b0;
									done_d = 1'b1;
									st_d   = B_IDLE;
								end
							endcase
						end
						CMD_STOP: begin
							case (ph_q)
								2'd0: sda_d = 1'b0;
								2'd1: scl_d = 1'b1;
								2'd2: sda_d = 1'b1;
								default: begin
									done_d = 1'b1;
									st_d   = B_IDLE;
								end
							endcase
						end
						default: begin
							case (ph_q)
								2'd0: begin
									if (bit_q == `CCS_ACK_BIT) begin
										sda_d = (cmd_q == CMD_RD) ? ~ack_q : 1'b1;
									end else begin
										sda_d = (cmd_q == CMD_RD) ? 1'b1 : sh_q[7];
									end
								end
								2'd1: scl_d = 1'b1;
								2'd2: begin
									// Hold the phase while the slave stretches the clock
									if (!scl_i) begin
										ph_d = ph_q;
									end else if (bit_q == `CCS_ACK_BIT) begin
										nack_d = sda_i;
									end else begin
										sh_d = {sh_q[6:0], sda_i};
									end
								end
								default: begin
									scl_d = 1'b0;
									if (bit_q == `CCS_ACK_BIT) begin
										done_d = 1'b1;
										st_d   = B_IDLE;
									end else begin
										bit_d = bit_q + 4'd1;
									end
								end
							endcase
						end
					endcase
				end
			end
			default: st_d = B_IDLE;
		endcase
	end

	// Engine registers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_q   <= B_IDLE;
			cmd_q  <= CMD_START;
			div_q  <= 16'h0000;
			ph_q   <= 2'd0;
			bit_q  <= 4'd0;
			sh_q   <= 8'h00;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			ack_q  <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			cmd_q  <= cmd_d;
			div_q  <= div_d;
			ph_q   <= ph_d;
			bit_q  <= bit_d;
			sh_q   <= sh_d;
			scl_q  <= scl_d;
			sda_q  <= sda_d;
			ack_q  <= ack_d;
			nack_q <= nack_d;
			done_q <= done_d;
		end
	end

	// Open drain: the pad only ever pulls low, a high comes from the pull-up
	assign scl_o      = 1'b0; // see [R1]
	assign sda_o      = 1'b0; // see [R1]
	assign scl_oe_n_o = scl_q; // see [R1]
	assign sda_oe_n_o = sda_q; // see [R1]
	assign ready_o    = (st_q == B_IDLE);
	assign done_o     = done_q;
	assign rdata_o    = sh_q;
	assign nack_o     = nack_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_data_edge;
		$changed(sda_oe_n_o) && st_q == B_RUN && (cmd_q == CMD_WR || cmd_q == CMD_RD);
	endsequence

	a_pins_pull_low: assert property (scl_o == 1'b0 && sda_o == 1'b0) // see [R1]
		else $error("two-wire pad driven high");
	a_data_scl_low: assert property (s_data_edge |-> !scl_oe_n_o) // see [R1]
		else $error("data moved while clock released");
endmodule

// File: verilog/ccs_top.sv
// Purpose: Fetches correction words from the serial EEPROM and applies them to converter data.
// Assumes: Selection is stable only at load_i; converter samples come as one-cycle valids.
// Notes:   Four reads per load: input record, input range, output record, output range.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_top #(
	parameter logic [6:0]  EE_DEV    = `CCS_DEV_DEF,
	parameter logic [15:0] SE_BASE   = `CCS_SE_BASE_DEF,
	parameter logic [15:0] ARNG_BASE = `CCS_ARNG_DEF,
	parameter logic [15:0] DAC_BASE  = `CCS_DAC_DEF,
	parameter logic [15:0] DRNG_BASE = `CCS_DRNG_DEF,
	parameter int          QTR       = `CCS_QTR_CYC
) (
	input  wire logic               ref_clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic               load_i,
	input  wire ccs_pkg::ccs_sel_s  sel_i,
	output logic                    busy_o,
	output logic                    loaded_o,
	output logic                    err_o,
	output ccs_pkg::ccs_corr_s      adc_corr_o,
	output ccs_pkg::ccs_corr_s      dac_corr_o,
	output logic [7:0]              adc_range_o,
	output logic [7:0]              dac_range_o,
	input  wire ccs_pkg::ccs_smp_s  adc_raw_i,
	output ccs_pkg::ccs_smp_s       adc_out_o,
	input  wire ccs_pkg::ccs_smp_s  dac_in_i,
	output ccs_pkg::ccs_smp_s       dac_out_o,
	input  wire logic               scl_i,
	output logic                    scl_o,
	output logic                    scl_oe_n_o,
	input  wire logic               sda_i,
	output logic                    sda_o,
	output logic                    sda_oe_n_o
);
	import ccs_pkg::*;

	ccs_seq_e    seq_q, seq_d;
	ccs_job_e    job_q, job_d;
	ccs_sel_s    sel_q, sel_d;
	ccs_gain_e   blk;
	ccs_corr_s   adc_q, adc_d, dac_q, dac_d;
	ccs_smp_s    aout_q, aout_d, dout_q, dout_d;
	logic [7:0]  byte_q [`CCS_REC_BYTES];
	logic [7:0]  byte_d [`CCS_REC_BYTES];
	logic [7:0]  arng_q, arng_d, drng_q, drng_d;
	logic [1:0]  cnt_q, cnt_d, last;
	logic        wait_q, wait_d, err_q, err_d, loaded_q, loaded_d;
	logic [15:0] rec_ofs, addr;
	ccs_cmd_e    cmd;
	logic [7:0]  wdata, eng_rdata;
	logic        cmd_valid, mack, eng_ready, eng_done, eng_nack;

	// ----------------------------------------
	// Correction arithmetic
	// ----------------------------------------
	// Work in half LSBs so an odd offset is not lost, then saturate back to 16 bits
	function automatic logic signed [15:0] ccs_apply(input logic signed [15:0] x, input ccs_corr_s c);
		logic signed [17:0] d2;
		logic signed [33:0] p;
		logic signed [18:0] y2;
		logic signed [17:0] y;
		d2 = (18'(x) <<< `CCS_FRAC_SHIFT) - 18'(c.offset); // see [R2] [R3] [R4] [R5]
		p  = 34'(d2) * 34'(c.gain); // see [R6] [R7]
		y2 = 19'(d2) + 19'(p >>> `CCS_GAIN_SHIFT);
		y  = 18'(y2 >>> `CCS_FRAC_SHIFT);
		if (y > `CCS_SAT_MAX) begin
			ccs_apply = `CCS_OUT_MAX;
		end else if (y < `CCS_SAT_MIN) begin
			ccs_apply = `CCS_OUT_MIN;
		end else begin
			ccs_apply = y[15:0];
		end
	endfunction

	// One pipeline stage per direction; the data outputs come from flip-flops
	always_comb begin
		aout_d = '{valid: adc_raw_i.valid, data: ccs_apply(adc_raw_i.data, adc_q)}; // see [R5] [R7]
		dout_d = '{valid: dac_in_i.valid, data: ccs_apply(dac_in_i.data, dac_q)}; // see [R4] [R6]
	end

	// ----------------------------------------
	// Byte map
	// ----------------------------------------
	// Single-ended 0.2 has no own set, so it falls back to the 0.16666 block
	always_comb begin
		blk     = (sel_q.se && sel_q.gain == G_0200) ? G_0166 : sel_q.gain; // see [R12]
		rec_ofs = (16'(blk) << `CCS_BLK_SHIFT) | (16'(sel_q.conv) << `CCS_CONV_SHIFT)
			| (16'(sel_q.ch) << `CCS_CH_SHIFT); // see [R8] [R10] [R11]
		case (job_q)
			J_ADC_REC: addr = (sel_q.se ? SE_BASE : `CCS_DIFF_BASE) + rec_ofs; // see [R9]
			J_ADC_RNG: addr = ARNG_BASE + 16'({sel_q.se, blk}); // see [R13]
			J_DAC_REC: addr = DAC_BASE + (16'(sel_q.dac_ch) << `CCS_CH_SHIFT);
			default:   addr = DRNG_BASE + 16'(sel_q.dac_ch); // see [R13]
		endcase
		last = (job_q == J_ADC_REC || job_q == J_DAC_REC) ? `CCS_REC_LAST : `CCS_RNG_LAST;
	end

	// ----------------------------------------
	// Fetch sequencer
	// ----------------------------------------
	// Command for the current step: random read = start, write address, restart, read
	always_comb begin
		cmd   = CMD_START;
		wdata = 8'h00;
		mack  = 1'b0;
		case (seq_q)
			S_DEVW:  begin cmd = CMD_WR; wdata = {EE_DEV, 1'b0}; end
			S_AHI:   begin cmd = CMD_WR; wdata = addr[15:8]; end
			S_ALO:   begin cmd = CMD_WR; wdata = addr[7:0]; end
			S_DEVR:  begin cmd = CMD_WR; wdata = {EE_DEV, 1'b1}; end
			S_READ:  begin cmd = CMD_RD; mack = (cnt_q != last); end
			S_STOP:  cmd = CMD_STOP;
			default: cmd = CMD_START;
		endcase
		cmd_valid = (seq_q != S_IDLE) && !wait_q;
	end

	// Step advance; a missing acknowledge ends the load with a stop and err_o
	always_comb begin
		seq_d    = seq_q;
		job_d    = job_q;
		sel_d    = sel_q;
		cnt_d    = cnt_q;
		wait_d   = wait_q;
		err_d    = err_q;
		loaded_d = loaded_q;
		byte_d   = byte_q;
		adc_d    = adc_q;
		dac_d    = dac_q;
		arng_d   = arng_q;
		drng_d   = drng_q;
		if (cmd_valid && eng_ready) begin
			wait_d = 1'b1;
		end
		if (eng_done) begin
			wait_d = 1'b0;
			case (seq_q)
				S_START:  seq_d = S_DEVW;
				S_DEVW:   seq_d = eng_nack ? S_STOP : S_AHI;
				S_AHI:    seq_d = eng_nack ? S_STOP : S_ALO;
				S_ALO:    seq_d = eng_nack ? S_STOP : S_RSTART;
				S_RSTART: seq_d = S_DEVR;
				S_DEVR:   seq_d = eng_nack ? S_STOP : S_READ;
				S_READ: begin
					byte_d[cnt_q] = eng_rdata; // see [R14]
					if (cnt_q == last) begin
						seq_d = S_STOP;
					end else begin
						cnt_d = cnt_q + 2'd1;
					end
				end
				S_STOP: begin
					cnt_d = 2'd0;
					if (err_q) begin
						seq_d = S_IDLE;
					end else begin
						// High byte from the lower address lands in the upper eight bits
						case (job_q)
							J_ADC_REC: adc_d = {byte_q[`CCS_B_OFS_HI], byte_q[`CCS_B_OFS_LO],
								byte_q[`CCS_B_GN_HI], byte_q[`CCS_B_GN_LO]}; // see [R9] [R14]
							J_ADC_RNG: arng_d = byte_q[0]; // see [R13]
							J_DAC_REC: dac_d = {byte_q[`CCS_B_OFS_HI], byte_q[`CCS_B_OFS_LO],
								byte_q[`CCS_B_GN_HI], byte_q[`CCS_B_GN_LO]}; // see [R9] [R14]
							default:   drng_d = byte_q[0]; // see [R13]
						endcase
						if (job_q == J_DAC_RNG) begin
							seq_d    = S_IDLE;
							loaded_d = 1'b1;
						end else begin
							job_d = ccs_job_e'(job_q + 2'd1);
							seq_d = S_START;
						end
					end
				end
				default: seq_d = S_IDLE;
			endcase
			if (seq_q == S_DEVW || seq_q == S_AHI || seq_q == S_ALO || seq_q == S_DEVR) begin
				err_d = err_q | eng_nack;
			end
		end
		if (seq_q == S_IDLE && load_i) begin
			sel_d    = sel_i;
			job_d    = J_ADC_REC;
			cnt_d    = 2'd0;
			err_d    = 1'b0;
			loaded_d = 1'b0;
			seq_d    = S_START;
		end
	end

	// Sequencer and datapath registers; corrections reset to identity
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			seq_q    <= S_IDLE;
			job_q    <= J_ADC_REC;
			sel_q    <= '0;
			cnt_q    <= 2'd0;
			wait_q   <= 1'b0;
			err_q    <= 1'b0;
			loaded_q <= 1'b0;
			byte_q   <= '{default: 8'h00};
			adc_q    <= '0;
			dac_q    <= '0;
			arng_q   <= 8'h00;
			drng_q   <= 8'h00;
			aout_q   <= '0;
			dout_q   <= '0;
		end else begin
			seq_q    <= seq_d;
			job_q    <= job_d;
			sel_q    <= sel_d;
			cnt_q    <= cnt_d;
			wait_q   <= wait_d;
			err_q    <= err_d;
			loaded_q <= loaded_d;
			byte_q   <= byte_d;
			adc_q    <= adc_d;
			dac_q    <= dac_d;
			arng_q   <= arng_d;
			drng_q   <= drng_d;
			aout_q   <= aout_d;
			dout_q   <= dout_d;
		end
	end

	ccs_i2c_bit #(.QTR(QTR)) u_bit (
		.ref_clk_i   (ref_clk_i),
		.sys_rst_i   (sys_rst_i),
		.cmd_valid_i (cmd_valid),
		.cmd_i       (cmd),
		.wdata_i     (wdata),
		.mack_i      (mack),
		.ready_o     (eng_ready),
		.done_o      (eng_done),
		.rdata_o     (eng_rdata),
		.nack_o      (eng_nack),
		.scl_i       (scl_i),
		.scl_o       (scl_o),
		.scl_oe_n_o  (scl_oe_n_o),
		.sda_i       (sda_i),
		.sda_o       (sda_o),
		.sda_oe_n_o  (sda_oe_n_o)
	);

	assign busy_o      = (seq_q != S_IDLE);
	assign loaded_o    = loaded_q;
	assign err_o       = err_q;
	assign adc_corr_o  = adc_q;
	assign dac_corr_o  = dac_q;
	assign adc_range_o = arng_q;
	assign dac_range_o = drng_q;
	assign adc_out_o   = aout_q;
	assign dac_out_o   = dout_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_commit(ccs_job_e j);
		seq_q == S_STOP && eng_done && !err_q && job_q == j;
	endsequence

	a_adc_off_sub: assert property ( // see [R3] [R5]
		adc_raw_i.valid && adc_q.gain == 16'sh0000 && !adc_q.offset[0] && adc_raw_i.data == 16'sh0000
		|=> adc_out_o.data == -($past(adc_q.offset) >>> 1) && adc_out_o.valid)
		else $error("input offset not subtracted in half LSBs");
	a_dac_off_sub: assert property ( // see [R4]
		dac_in_i.valid && dac_q.gain == 16'sh0000 && !dac_q.offset[0]
		&& dac_in_i.data >= -16'sh4000 && dac_in_i.data < 16'sh4000
		|=> dac_out_o.data == $past(dac_in_i.data) - ($past(dac_q.offset) >>> 1))
		else $error("output offset not subtracted");
	a_dac_gain_unity: assert property ( // see [R6]
		dac_q == '0 ##1 dac_q == '0 |-> dac_out_o.data == $past(dac_in_i.data))
		else $error("zero gain word must give unity factor");
	a_adc_gain_scale: assert property ( // see [R7]
		adc_q.offset == 16'sh0000 && adc_q.gain == 16'sh4000 && adc_raw_i.data == 16'sh4000
		|=> adc_out_o.data == 16'sh4800)
		else $error("input gain factor wrong");
	a_signed_offset: assert property ( // see [R2]
		adc_q.gain == 16'sh0000 && adc_q.offset == 16'shFFFE && adc_raw_i.data == 16'sh8000
		|=> adc_out_o.data == 16'sh8001)
		else $error("offset not treated as signed");
	a_word_pack: assert property (s_commit(J_ADC_REC) |=> adc_q == // see [R9] [R14]
		$past({byte_q[0], byte_q[1], byte_q[2], byte_q[3]}))
		else $error("record bytes packed in wrong order");
	a_range_byte: assert property (s_commit(J_DAC_RNG) |=> drng_q == $past(byte_q[0]) && loaded_o) // see [R13]
		else $error("range byte not captured");
	a_rec_align: assert property (job_q == J_ADC_REC && busy_o |-> rec_ofs[1:0] == 2'b00 // see [R10] [R11]
		&& rec_ofs[6] == 1'b0 && rec_ofs[5:2] == {sel_q.conv, sel_q.ch})
		else $error("record address outside its block");
	a_se_shared: assert property (sel_q.se && sel_q.gain == G_0200 && busy_o // see [R12]
		|-> rec_ofs[8:7] == 2'b00)
		else $error("single-ended 0.2 not using shared set");
endmodule

// File: dv/ccs_ee_model.sv
// Purpose: Behavioural two-wire EEPROM for the correction store bench.
// Assumes: Pull-ups on both lines; no clock stretching; two address bytes.
// Notes:   Acks only its own device code; nak_i refuses the device byte.
`timescale 1ns/1ps
module ccs_ee_model #(
	parameter logic [6:0] DEV = 7'h50
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	input  wire logic nak_i,
	output logic      sda_low_o
);
	logic [7:0]  mem [0:16383];
	logic [15:0] ptr;
	logic [7:0]  b;
	logic        ok;

	// Shift in one byte on clock highs, then answer in the ninth bit
	task automatic get_byte(input logic dev);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl_i);
			b = {b[6:0], sda_i};
		end
		ok = !dev || (b[7:1] == DEV && !nak_i);
		@(negedge scl_i);
		sda_low_o = ok;
		@(negedge scl_i);
		sda_low_o = 1'b0;
	endtask

	// Data changes only while the clock is low; released bits float high
	task automatic put_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			sda_low_o = ~d[i];
			@(negedge scl_i);
		end
		sda_low_o = 1'b0;
		@(posedge scl_i);
		ok = ~sda_i;
		@(negedge scl_i);
	endtask

	// Pattern fill so a wrong address shows up as wrong data
	initial begin
		sda_low_o = 1'b0;
		for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'hA5;
		forever begin
			@(negedge sda_i iff scl_i === 1'b1);
			get_byte(1'b1);
			if (ok && !b[0]) begin
				get_byte(1'b0);
				ptr[15:8] = b;
				get_byte(1'b0);
				ptr[7:0] = b;
			end else if (ok) begin
				ok = 1'b1;
				while (ok) begin
					put_byte(mem[ptr[13:0]]);
					ptr = ptr + 16'h0001;
				end
			end
		end
	end
endmodule

// File: dv/ccs_top_tb_top.sv
// Purpose: Self-checking bench of the correction store.
// Assumes: QTR shortened to 2; byte map as chosen in the design.
// Notes:   Table rows first, then refusal, missing ack and mid-run reset.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_top_tb_top;
	import ccs_pkg::*;
	typedef struct {
		ccs_sel_s    sel;
		logic [15:0] ofs;
		logic [15:0] gn;
		logic [15:0] x;
		logic [15:0] y;
	} ccs_row_s;
	logic      ref_clk_i, sys_rst_i, load_i, nak, sda_low;
	ccs_sel_s  sel_i;
	ccs_smp_s  adc_raw_i, dac_in_i, adc_out_o, dac_out_o;
	ccs_corr_s adc_corr_o, dac_corr_o;
	logic      busy_o, loaded_o, err_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
	logic [7:0] adc_range_o, dac_range_o;
	int        failures = 0;
	int        n_tests = 0;
	ccs_row_s  r;
	wire       sda_line = sda_oe_n_o & ~sda_low;
	ccs_row_s  rows [7] = '{
		'{'{2'd0, 2'd0, G_0166, 1'b0, 3'd0}, 16'h0000, 16'h4000, 16'h4000, 16'h4800},
		'{'{2'd3, 2'd3, G_0800, 1'b0, 3'd7}, 16'h0010, 16'hC000, 16'h8000, 16'h8FF9},
		'{'{2'd1, 2'd2, G_0200, 1'b0, 3'd3}, 16'h8000, 16'h7FFF, 16'h7FFF, 16'h7FFF},
		'{'{2'd2, 2'd1, G_0400, 1'b0, 3'd5}, 16'h7FFE, 16'h0000, 16'h0000, 16'hC001},
		'{'{2'd0, 2'd1, G_0200, 1'b1, 3'd1}, 16'hFFFE, 16'h1234, 16'hF000, 16'hEF6F},
		'{'{2'd1, 2'd0, G_0166, 1'b0, 3'd2}, 16'hFFFE, 16'h0000, 16'h8000, 16'h8001},
		'{'{2'd2, 2'd3, G_0800, 1'b0, 3'd4}, 16'h0E0F, 16'h00F0, 16'h0000, 16'hF8F5}};

	ccs_top #(.QTR(2)) uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .load_i(load_i), .sel_i(sel_i),
		.busy_o(busy_o), .loaded_o(loaded_o), .err_o(err_o), .adc_corr_o(adc_corr_o), .dac_corr_o(dac_corr_o),
		.adc_range_o(adc_range_o), .dac_range_o(dac_range_o), .adc_raw_i(adc_raw_i), .adc_out_o(adc_out_o),
		.dac_in_i(dac_in_i), .dac_out_o(dac_out_o), .scl_i(scl_oe_n_o), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
	ccs_ee_model ee (.scl_i(scl_oe_n_o), .sda_i(sda_line), .nak_i(nak), .sda_low_o(sda_low));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Reference arithmetic, worked in wide signed integers
	function automatic logic [15:0] fix(input logic [15:0] x, input logic [15:0] o, input logic [15:0] g);
		longint d2, y;
		d2 = 2 * longint'($signed(x)) - longint'($signed(o));
		y = (d2 + ((d2 * longint'($signed(g))) >>> 17)) >>> 1;
		if (y > 32767) y = 32767;
		if (y < -32768) y = -32768;
		return y[15:0];
	endfunction

	function automatic logic [15:0] rec_addr(input ccs_sel_s s);
		logic [1:0] blk;
		blk = (s.se && s.gain == G_0200) ? 2'h0 : s.gain;
		return (s.se ? `CCS_SE_BASE_DEF : 16'h0000) + 16'(blk) * 16'h0080 + 16'(s.conv) * 16'h0010
			+ 16'(s.ch) * 16'h0004;
	endfunction

	task automatic put_rec(input logic [15:0] a, input logic [15:0] o, input logic [15:0] g);
		{ee.mem[a], ee.mem[a + 1], ee.mem[a + 2], ee.mem[a + 3]} = {o, g};
	endtask

	// Wait bound is far above one four-read fetch at this quarter length
	task automatic fetch(input ccs_sel_s s, input logic poke);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		load_i <= 1'b1;
		sel_i <= s;
		@(posedge ref_clk_i);
		load_i <= 1'b0;
		if (poke) begin
			repeat (100) @(posedge ref_clk_i);
			load_i <= 1'b1;
			sel_i <= ccs_sel_s'(~s);
			@(posedge ref_clk_i);
			load_i <= 1'b0;
		end
		do @(negedge ref_clk_i); while (busy_o !== 1'b0 && ++n < 20000);
		chk("busy", busy_o, 0);
	endtask

	task automatic do_reset();
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("reset_flags", {busy_o, loaded_o, err_o, scl_oe_n_o, sda_oe_n_o, adc_out_o.valid, dac_out_o.valid}, 7'h0C);
		chk("reset_corr", {adc_corr_o, dac_corr_o}, 64'h0);
	endtask

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	// A hang counts as a mismatch and closes the run the normal way
	initial begin
		#2000000;
		failures++;
		$display("ERROR watchdog expected idle seen hang");
		results();
	end

	initial begin
		sys_rst_i = 1'b1;
		load_i = 1'b0;
		sel_i = '0;
		adc_raw_i = '0;
		dac_in_i = '0;
		nak = 1'b0;
		do_reset();
		for (int j = 0; j < 8; j++) begin
			ee.mem[`CCS_ARNG_DEF + j] = 8'hA0 + 8'(j);
			ee.mem[`CCS_DRNG_DEF + j] = 8'hD0 + 8'(j);
		end
		foreach (rows[i]) begin
			r = rows[i];
			put_rec(rec_addr(r.sel), r.ofs, r.gn);
			put_rec(`CCS_DAC_DEF + 16'(r.sel.dac_ch) * 16'h0004, r.ofs ^ 16'h0F0F, r.gn ^ 16'h00F0);
			fetch(r.sel, 1'b0);
			chk("loaded_err", {loaded_o, err_o}, 2'b10);
			chk("adc_corr", adc_corr_o, {r.ofs, r.gn});
			chk("dac_corr", dac_corr_o, {r.ofs ^ 16'h0F0F, r.gn ^ 16'h00F0});
			if (!r.sel.se) chk("adc_range", adc_range_o, 8'hA0 + 8'(r.sel.gain));
			chk("dac_range", dac_range_o, 8'hD0 + 8'(r.sel.dac_ch));
			chk("pins_low", {scl_o, sda_o}, 0);
			@(posedge ref_clk_i);
			adc_raw_i <= '{1'b1, r.x};
			dac_in_i <= '{1'b1, r.x};
			@(posedge ref_clk_i);
			adc_raw_i <= '0;
			dac_in_i <= '0;
			@(negedge ref_clk_i);
			chk("adc_out", adc_out_o, {1'b1, r.y});
			chk("dac_out", dac_out_o, {1'b1, fix(r.x, r.ofs ^ 16'h0F0F, r.gn ^ 16'h00F0)});
			@(negedge ref_clk_i);
			chk("out_idle", {adc_out_o.valid, dac_out_o.valid}, 0);
			$display("row %0d done", i);
		end
		// A second load while busy must leave the first selection in force
		fetch(rows[0].sel, 1'b1);
		chk("refused_load", adc_corr_o, {rows[0].ofs, rows[0].gn});
		$display("refused load test done");
		// Missing ack: error flag, old corrections kept
		nak = 1'b1;
		fetch(rows[1].sel, 1'b0);
		chk("nack_flags", {loaded_o, err_o}, 2'b01);
		chk("nack_keep", adc_corr_o, {rows[0].ofs, rows[0].gn});
		nak = 1'b0;
		fetch(rows[1].sel, 1'b0);
		chk("retry_flags", {loaded_o, err_o}, 2'b10);
		$display("missing ack test done");
		// Reset in mid-fetch returns everything to the released state
		@(posedge ref_clk_i);
		load_i <= 1'b1;
		@(posedge ref_clk_i);
		load_i <= 1'b0;
		repeat (300) @(posedge ref_clk_i);
		do_reset();
		// Corrections back at identity: samples pass through unchanged
		@(posedge ref_clk_i);
		adc_raw_i <= '{1'b1, 16'h1234};
		dac_in_i <= '{1'b1, 16'h8765};
		@(posedge ref_clk_i);
		adc_raw_i <= '0;
		dac_in_i <= '0;
		@(negedge ref_clk_i);
		chk("reset_identity", {adc_out_o, dac_out_o}, {1'b1, 16'h1234, 1'b1, 16'h8765});
		$display("mid-run reset test done");
		results();
	end
endmodule
